// ---- rtl/port_l_gpio_regs.vh ----
/*
 * register offsets, field positions, reset values and timing for the port L gpio block.
 * assumes a 32-bit classic wishbone slave with byte addresses.
 */
`ifndef PORT_L_GPIO_REGS_VH
`define PORT_L_GPIO_REGS_VH

`define PORT_OUTPUT_LATCH_ADDR 32'hFFFFF75E
`define PORT_PIN_LEVEL_ADDR    32'hFFFFF788
`define PORT_PIN_COUNT         14
`define PORT_PIN_MSB           13
`define PORT_LATCH_RESET       14'h0000
`define PORT_REG_WIDTH         16
`define PORT_RSVD_ZERO         2'h0
`define PORT_ACCESS_WAIT       3'h4
`define PORT_UNMAPPED_DATA     32'h00000000

`endif

// ---- rtl/port_l_gpio.v ----
/*
 * port L general purpose io: output latch register, pin level register,
 * per-pin drive control, classic wishbone slave.
 * assumes direction and function select come from an outside controller,
 * and that standby and watchdog reset qualifiers are supplied as levels.
 */
// Added by the designer: the Wishbone register port.
`timescale 1ns/1ps
`include "port_l_gpio_regs.vh"

module port_l_gpio (
    // clock and reset
    input  wire        clk,
    input  wire        rstn,
    // power state
    input  wire        wdtReset,
    input  wire        hwStandby,
    // wishbone slave
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [31:0] wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    // port control
    input  wire [13:0] pinDirectionSelect,
    input  wire [13:0] generalFunction,
    input  wire [13:0] peripheralOut,
    // pins
    input  wire [13:0] pinIn,
    output reg  [13:0] pinOut,
    output reg  [13:0] pinOeN
);

////////////////////////////////////////////////////////////////////////////////

localparam ST_IDLE = 2'h0;
localparam ST_WAIT = 2'h1;
localparam ST_ACK  = 2'h2;
localparam ST_DONE = 2'h3;

reg  [13:0] latchBits_reg;
reg  [13:0] latchBits_next;
reg  [13:0] syncStage1_reg;
reg  [13:0] levelBits_reg;
reg  [1:0]  state_reg;
reg  [1:0]  state_next;
reg  [2:0]  waitCount_reg;
reg  [2:0]  waitCount_next;
reg  [31:0] readData;
reg  [13:0] latchView;
reg  [15:0] laneWord;
wire        request;
wire        hitLatch;
wire        hitLevel;
wire [15:0] writeMask;

// picks the 16-bit half and byte lanes of a word for a halfword register
function [15:0] lane_mask;
    input [31:0] adr;
    input [3:0]  sel;
    begin
        if (adr[1]) begin
            lane_mask = {{8{sel[1]}}, {8{sel[0]}}};
        end else begin
            lane_mask = {{8{sel[3]}}, {8{sel[2]}}};
        end
    end
endfunction

function reg_hit;
    input [31:0] adr;
    input [31:0] base;
    begin
        reg_hit = (adr[31:2] == base[31:2]);
    end
endfunction

assign request   = wb_cyc_i & wb_stb_i;
assign hitLatch  = reg_hit(wb_adr_i, `PORT_OUTPUT_LATCH_ADDR);
assign hitLevel  = reg_hit(wb_adr_i, `PORT_PIN_LEVEL_ADDR);
assign writeMask = lane_mask(wb_adr_i, wb_sel_i);

////////////////////////////////////////////////////////////////////////////////
// pin synchroniser

always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
        syncStage1_reg <= 14'h0000;
        levelBits_reg  <= 14'h0000;
    end else begin
        syncStage1_reg <= pinIn;
        levelBits_reg  <= syncStage1_reg;
    end
end

////////////////////////////////////////////////////////////////////////////////
// bus timing: four cycles from take to ack

always @* begin
    state_next     = state_reg;
    waitCount_next = waitCount_reg;
    case (state_reg)
        ST_IDLE: begin
            if (request) begin
                state_next     = ST_WAIT;
                waitCount_next = 3'h1;
            end
        end
        ST_WAIT: begin
            waitCount_next = waitCount_reg + 3'h1;
            if (waitCount_reg == (`PORT_ACCESS_WAIT - 3'h1)) begin
                state_next = ST_ACK;
            end
        end
        ST_ACK: begin
            state_next = ST_DONE;
        end
        ST_DONE: begin
            if (!request) begin
                state_next = ST_IDLE;
            end
        end
        default: begin
            state_next = ST_IDLE;
        end
    endcase
end

////////////////////////////////////////////////////////////////////////////////
// register read and write

always @* begin
    latchView = (latchBits_reg & pinDirectionSelect)
              | (levelBits_reg & ~pinDirectionSelect);
    readData  = `PORT_UNMAPPED_DATA;
    laneWord  = 16'h0000;
    if (hitLatch) begin
        laneWord = {`PORT_RSVD_ZERO, latchView};
    end else if (hitLevel) begin
        laneWord = {`PORT_RSVD_ZERO, levelBits_reg};
    end
    if (wb_adr_i[1]) begin
        readData = {16'h0000, laneWord};
    end else begin
        readData = {laneWord, 16'h0000};
    end
end

always @* begin
    latchBits_next = latchBits_reg;
    if (state_reg == ST_WAIT && waitCount_reg == (`PORT_ACCESS_WAIT - 3'h1)
        && wb_we_i && hitLatch) begin
        // byte lanes only, reserved bits dropped
        if (wb_adr_i[1]) begin
            latchBits_next = (latchBits_reg & ~writeMask[13:0])
                           | (wb_dat_i[13:0] & writeMask[13:0]);
        end else begin
            latchBits_next = (latchBits_reg & ~writeMask[13:0])
                           | (wb_dat_i[29:16] & writeMask[13:0]);
        end
    end
end

always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
        state_reg     <= ST_IDLE;
        waitCount_reg <= 3'h0;
        latchBits_reg <= `PORT_LATCH_RESET;
        wb_ack_o      <= 1'b0;
        wb_dat_o      <= 32'h00000000;
    end else begin
        state_reg     <= state_next;
        waitCount_reg <= waitCount_next;
        if (hwStandby) begin
            latchBits_reg <= `PORT_LATCH_RESET;
        end else begin
            latchBits_reg <= latchBits_next;
        end
        wb_ack_o <= (state_next == ST_ACK);
        if (state_next == ST_ACK && !wb_we_i) begin
            wb_dat_o <= readData;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// pin drive

always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
        pinOut <= 14'h0000;
        pinOeN <= 14'h3FFF;
    end else begin
        pinOeN <= ~pinDirectionSelect;
        if (hwStandby) begin
            // a cleared latch must not leak a same-cycle write onto the pins
            pinOut <= peripheralOut & ~generalFunction;
        end else begin
            pinOut <= (latchBits_next & generalFunction)
                    | (peripheralOut & ~generalFunction);
        end
    end
end

endmodule // port_l_gpio

// ---- test/port_l_gpio_assertions.sv ----
/* checker for port_l_gpio: bus answer timing and pin drive.
   assumes it is bound to port_l_gpio and sees its ports only. */
`timescale 1ns/1ps
module port_l_gpio_assertions (
    input wire        clk, rstn, hwStandby, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o,
    input wire [31:0] wb_adr_i, wb_dat_i, wb_dat_o,
    input wire [3:0]  wb_sel_i,
    input wire [13:0] pinDirectionSelect, generalFunction, peripheralOut, pinOut, pinOeN
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    chk_ack_delay: assert property ($rose(wb_cyc_i && wb_stb_i) |-> ##[4:5] wb_ack_o)
        else $error("late bus answer");
    chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack too long");
    chk_ack_cause: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
        else $error("ack without request");
    chk_oe_dir: assert property ($past(rstn) |-> pinOeN == ~$past(pinDirectionSelect))
        else $error("drive enable wrong");
    chk_rsvd_zero: assert property (wb_ack_o |-> wb_dat_o[31:30] == 2'h0 && wb_dat_o[15:14] == 2'h0)
        else $error("reserved bits set");
    chk_standby_clr: assert property (hwStandby[*3] |-> (pinOut & generalFunction) == 14'h0)
        else $error("latch not cleared");
    chk_periph_out: assert property ($past(rstn) |->
        ((pinOut ^ $past(peripheralOut)) & ~$past(generalFunction)) == 14'h0)
        else $error("peripheral drive wrong");
    chk_write_pin: assert property (wb_ack_o && wb_we_i && wb_adr_i == 32'hFFFFF75E
        && wb_sel_i == 4'h3 |-> ((pinOut ^ wb_dat_i[13:0]) & generalFunction) == 14'h0)
        else $error("write not on pins");
endmodule // port_l_gpio_assertions

// ---- test/pin_level_model.sv ----
/* external pins: each pin shows the block drive or an outside level.
   assumes active low drive enables. */
`timescale 1ns/1ps
module pin_level_model (
    input wire [13:0]  pinOut, pinOeN, extLevel,
    output wire [13:0] pinLevel
);
    assign pinLevel = (pinOut & ~pinOeN) | (extLevel & pinOeN);
endmodule // pin_level_model

// ---- test/port_l_gpio_tb.sv ----
/* testbench for port_l_gpio over classic wishbone.
   assumes the pin model and checker are compiled first. */
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_errors++; $display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module port_l_gpio_tb;
    localparam [31:0] LATCH = 32'hFFFFF75E, LEVEL = 32'hFFFFF788;
    reg         clk = 0, rstn = 0, hwStandby = 0, cyc = 0, we = 0;
    reg  [31:0] adr = 0, dat = 0;
    reg  [3:0]  sel = 0;
    reg  [13:0] dir = 14'h3FFF, gf = 14'h3FFF, perOut = 0, ext = 14'h1234;
    wire [31:0] datO;
    wire        ack;
    wire [13:0] pinOut, pinOeN, pinLevel;
    reg  [15:0] rd;
    integer     n_errors = 0, n_checks = 0, i;
    always #20 clk = ~clk;
    port_l_gpio port_l_gpio_i (.clk(clk), .rstn(rstn), .wdtReset(1'b0), .hwStandby(hwStandby),
        .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(dat), .wb_dat_o(datO), .wb_ack_o(ack), .pinDirectionSelect(dir),
        .generalFunction(gf), .peripheralOut(perOut), .pinIn(pinLevel), .pinOut(pinOut),
        .pinOeN(pinOeN));
    pin_level_model pin_level_model_i (.pinOut(pinOut), .pinOeN(pinOeN), .extLevel(ext),
        .pinLevel(pinLevel));
    ////////////////////////////////////////////////////////////////////////////////
    task end_sim;
        begin
            $display("checks %0d mismatches %0d", n_checks, n_errors);
            if (n_errors == 0 && n_checks > 0) $display("== PASSED ==");
            else $display("== FAILED ==");
            $finish;
        end
    endtask
    // one bus cycle; the lane follows address bit 1
    task acc(input w, input [31:0] a, input [1:0] s, input [15:0] d);
        begin
            @(posedge clk);
            cyc <= 1;
            we <= w;
            adr <= a;
            sel <= a[1] ? {2'b0, s} : {s, 2'b0};
            dat <= a[1] ? {16'h0, d} : {d, 16'h0};
            i = 0;
            do begin @(posedge clk); i++; end while (ack !== 1'b1 && i < 20);
            if (ack !== 1'b1) begin n_errors++; end_sim; end
            rd = a[1] ? datO[15:0] : datO[31:16];
            cyc <= 0;
        end
    endtask
    task rdc(input [31:0] a, input [15:0] e);
        begin acc(0, a, 2'h3, 16'h0); `CHK(rd, e) end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(posedge clk);
        rstn <= 1;
        rdc(LATCH, 16'h0000);
        rdc(LEVEL, 16'h0000);
        acc(1, LATCH, 2'h3, 16'h2C35);
        rdc(LATCH, 16'h2C35);
        rdc(LEVEL, 16'h2C35);
        acc(1, LATCH, 2'h1, 16'h00A1);
        rdc(LATCH, 16'h2CA1);
        $display("test 1 done");
        dir <= 14'h0;
        rdc(LATCH, 16'h1234);
        acc(1, LATCH, 2'h3, 16'h0F0F);
        rdc(LEVEL, 16'h1234);
        dir <= 14'h3FFF;
        rdc(LATCH, 16'h0F0F);
        $display("test 2 done");
        gf <= 14'h0;
        perOut <= 14'h3C3C;
        rdc(LEVEL, 16'h3C3C);
        acc(1, LATCH, 2'h3, 16'h0001);
        rdc(LEVEL, 16'h3C3C);
        rdc(LATCH, 16'h0001);
        dir <= 14'h0;
        rdc(LATCH, 16'h1234);
        acc(1, LEVEL, 2'h3, 16'h0000);
        rdc(LEVEL, 16'h1234);
        rdc(32'hFFFFF700, 16'h0000);
        $display("test 3 done");
        gf <= 14'h3FFF;
        hwStandby <= 1;
        repeat (4) @(posedge clk);
        hwStandby <= 0;
        dir <= 14'h3FFF;
        rdc(LATCH, 16'h0000);
        $display("test 4 done");
        end_sim;
    end
endmodule // port_l_gpio_tb
bind port_l_gpio port_l_gpio_assertions port_l_gpio_assertions_i (.*);
